// >>> common/ppc_map.vh
// What this block does
// - The inverter supply command stays within 2 V to 12 V, set in 0.5 mV steps.
// - The switching frequency command stays within 101 kHz to 115 kHz.
// - The duty cycle command stays within 2 percent to 50 percent.
// - Every ping drives 108 kHz with an inverter supply between 3.5 V and 7.5 V.
// - With no signal strength message inside the ping window, power is removed.
// - Each retried ping uses a higher supply until an acceptable strength value comes or the 7.5 V ping also fails.
// - In transfer a PID update acts on supply voltage, frequency and duty cycle.
// - Supply voltage is adjusted first; frequency moves only once it saturates, and duty only once frequency saturates too.
// - Coil current is taken with a 1 mA step, finer than the 5 mA needed.
// - The voltage loop has unit proportional gain, cap 1500 and -0.5 mV per unit.
// - The frequency loop has unit proportional gain, cap 20000 and 1 Hz per unit.
// - The duty loop has unit proportional gain, cap 20000 and -0.1 percent per unit.
// - Receiver messages are decoded and steer the ping and power control sequence.
`ifndef PPC_MAP_VH
`define PPC_MAP_VH

// ----------------------------------------
// supply command, 0.5 mV per step
// ----------------------------------------
`define PPC_VIN_MIN        15'h0FA0
`define PPC_VIN_MAX        15'h5DC0
`define PPC_PING_VIN_START 15'h1B58
`define PPC_PING_VIN_LAST  15'h3A98
`define PPC_PING_VIN_STEP  15'h03E8

// ----------------------------------------
// frequency in Hz, duty in 0.1 percent
// ----------------------------------------
`define PPC_FREQ_MIN       17'h18A88
`define PPC_FREQ_MAX       17'h1C138
`define PPC_FREQ_PING      17'h1A5E0
`define PPC_DUTY_MIN       9'h014
`define PPC_DUTY_MAX       9'h1F4

// ----------------------------------------
// loop gains, caps and scale signs
// ----------------------------------------
`define PPC_PROPORTIONAL_GAIN 1
`define PPC_INTEGRAL_GAIN     0
`define PPC_DERIVATIVE_GAIN   0
`define PPC_VIN_OUTPUT_CAP    1500
`define PPC_FREQ_OUTPUT_CAP   20000
`define PPC_DUTY_OUTPUT_CAP   20000
`define PPC_VIN_SCALE_NEG     1
`define PPC_FREQ_SCALE_NEG    0
`define PPC_DUTY_SCALE_NEG    1

// ----------------------------------------
// receiver message headers and threshold
// ----------------------------------------
`define PPC_HDR_SIG_STRENGTH 8'h01
`define PPC_HDR_END_POWER    8'h02
`define PPC_HDR_CTRL_ERROR   8'h03
`define PPC_SS_ACCEPT_MIN    8'h20

// ----------------------------------------
// timing
// ----------------------------------------
`define PPC_CLK_KHZ      125000
`define PPC_PING_WIN_MS  65
`define PPC_PING_OFF_MS  20
`define PPC_PING_WIN_CYC (`PPC_PING_WIN_MS * `PPC_CLK_KHZ)
`define PPC_PING_OFF_CYC (`PPC_PING_OFF_MS * `PPC_CLK_KHZ)

`endif

// >>> rtl/ppc_loop_step.v
`timescale 1ns/1ns
`include "ppc_map.vh"

// one proportional loop: gain, output cap, scale sign, then range saturation
module ppc_loop_step #(
  parameter W    = 17,
  parameter CAP  = 1500,
  parameter NEG  = 0,
  parameter MINV = 0,
  parameter MAXV = 1
) (
  // loop input
  input  wire signed [24:0]  i_err,
  input  wire        [W-1:0] i_cur,
  // loop result
  output wire        [W-1:0] o_next,
  output wire                o_sat
);

  // integer constants cut to the 28-bit datapath on purpose
  localparam signed [31:0] GAIN_I = `PPC_PROPORTIONAL_GAIN;
  localparam signed [31:0] CAP_I  = CAP;
  localparam signed [31:0] MIN_I  = MINV;
  localparam signed [31:0] MAX_I  = MAXV;
  localparam signed [27:0] GAIN_S = GAIN_I[27:0];
  localparam signed [27:0] CAP_S  = CAP_I[27:0];
  localparam signed [27:0] MIN_S  = MIN_I[27:0];
  localparam signed [27:0] MAX_S  = MAX_I[27:0];

  wire signed [27:0] err_x;
  wire signed [55:0] gain_prod;
  wire signed [27:0] raw;
  wire signed [27:0] pid;
  wire signed [27:0] step;
  wire signed [27:0] sum;

  // integral and derivative gains are zero, so only the proportional term exists
  assign err_x     = {{3{i_err[24]}}, i_err};
  assign gain_prod = err_x * GAIN_S;
  assign raw       = gain_prod[27:0];
  // output cap keeps one packet from slewing the inverter too far
  assign pid  = (raw > CAP_S) ? CAP_S : ((raw < -CAP_S) ? -CAP_S : raw);
  assign step = (NEG != 0) ? -pid : pid;
  assign sum  = $signed({{(28-W){1'b0}}, i_cur}) + step;

  assign o_next = (sum > MAX_S) ? MAX_S[W-1:0] :
                  ((sum < MIN_S) ? MIN_S[W-1:0] : sum[W-1:0]);
  assign o_sat  = (sum > MAX_S) || (sum < MIN_S);

endmodule // ppc_loop_step

// >>> rtl/ppc_ctrl.v
`timescale 1ns/1ns
`include "ppc_map.vh"

// transmitter ping sequencing and closed-loop power control
module ppc_ctrl #(
  parameter PING_WIN_CYC = `PPC_PING_WIN_CYC,
  parameter PING_OFF_CYC = `PPC_PING_OFF_CYC
) (
  // clock and reset
  input  wire        i_core_clk,
  input  wire        i_rst_n,
  // system control
  input  wire        i_enable,
  // decoded receiver messages
  input  wire        i_pkt_valid,
  input  wire [7:0]  i_pkt_hdr,
  input  wire [7:0]  i_pkt_data,
  // coil current sense, 1 mA per step
  input  wire [15:0] i_coil_ma,
  // inverter commands
  output reg         o_power_en,
  output reg  [14:0] o_vin_half_mv,
  output reg  [16:0] o_freq_hz,
  output reg  [8:0]  o_duty_pmil,
  // status
  output reg         o_xfer_active,
  output reg         o_ping_fail
);

  // ----------------------------------------
  // states
  // ----------------------------------------
  localparam [3:0] ST_IDLE = 4'h1;
  localparam [3:0] ST_PING = 4'h2;
  localparam [3:0] ST_OFF  = 4'h4;
  localparam [3:0] ST_XFER = 4'h8;

  // counts are cut to the 24-bit timer on purpose; defaults stay below 2^24
  localparam [31:0] WIN_M1   = PING_WIN_CYC - 1;
  localparam [31:0] OFF_M1   = PING_OFF_CYC - 1;
  localparam [23:0] WIN_LAST = WIN_M1[23:0];
  localparam [23:0] OFF_LAST = OFF_M1[23:0];

  reg  [3:0]  state_q;
  reg  [3:0]  state_d;
  reg  [23:0] tmr_q;
  reg  [23:0] tmr_d;
  reg  [14:0] vin_d;
  reg  [16:0] freq_d;
  reg  [8:0]  duty_d;
  reg         fail_d;

  // ----------------------------------------
  // message decode
  // ----------------------------------------
  // header decode
  wire is_ss  = i_pkt_valid && (i_pkt_hdr == `PPC_HDR_SIG_STRENGTH);
  wire is_end = i_pkt_valid && (i_pkt_hdr == `PPC_HDR_END_POWER);
  wire is_ce  = i_pkt_valid && (i_pkt_hdr == `PPC_HDR_CTRL_ERROR);
  wire ss_ok  = is_ss && (i_pkt_data >= `PPC_SS_ACCEPT_MIN);

  // ----------------------------------------
  // loop error from control error value
  // ----------------------------------------
  // current feedback in mA
  // error is the requested fractional change of coil current, ce/128 of it
  wire signed [24:0] ce_prod;
  wire signed [24:0] loop_err;
  assign ce_prod  = $signed(i_pkt_data) * $signed({1'b0, i_coil_ma});
  assign loop_err = ce_prod >>> 7;

  wire [14:0] vin_next;
  wire [16:0] freq_next;
  wire [8:0]  duty_next;
  wire        vin_sat;
  wire        freq_sat;
  wire        duty_sat;

  ppc_loop_step #(
    .W    (15),
    .CAP  (`PPC_VIN_OUTPUT_CAP),
    .NEG  (`PPC_VIN_SCALE_NEG),
    .MINV (`PPC_VIN_MIN),
    .MAXV (`PPC_VIN_MAX)
  ) u_vin_loop (
    .i_err  (loop_err),
    .i_cur  (o_vin_half_mv),
    .o_next (vin_next),
    .o_sat  (vin_sat)
  );

  ppc_loop_step #(
    .W    (17),
    .CAP  (`PPC_FREQ_OUTPUT_CAP),
    .NEG  (`PPC_FREQ_SCALE_NEG),
    .MINV (`PPC_FREQ_MIN),
    .MAXV (`PPC_FREQ_MAX)
  ) u_freq_loop (
    .i_err  (loop_err),
    .i_cur  (o_freq_hz),
    .o_next (freq_next),
    .o_sat  (freq_sat)
  );

  ppc_loop_step #(
    .W    (9),
    .CAP  (`PPC_DUTY_OUTPUT_CAP),
    .NEG  (`PPC_DUTY_SCALE_NEG),
    .MINV (`PPC_DUTY_MIN),
    .MAXV (`PPC_DUTY_MAX)
  ) u_duty_loop (
    .i_err  (loop_err),
    .i_cur  (o_duty_pmil),
    .o_next (duty_next),
    .o_sat  (duty_sat)
  );

  // ----------------------------------------
  // sequencing
  // ----------------------------------------
  // next state and next commands
  always @* begin
    state_d = state_q;
    tmr_d   = tmr_q;
    vin_d   = o_vin_half_mv;
    freq_d  = o_freq_hz;
    duty_d  = o_duty_pmil;
    fail_d  = o_ping_fail;
    case (state_q)
      ST_IDLE: begin
        tmr_d = 24'h000000;
        // a failed sequence keeps its flag until enable is lowered
        if (i_enable && !o_ping_fail) begin
          state_d = ST_PING;
          vin_d   = `PPC_PING_VIN_START;
          freq_d  = `PPC_FREQ_PING;
          duty_d  = `PPC_DUTY_MAX;
          fail_d  = 1'b0;
        end
      end
      ST_PING: begin
        tmr_d = tmr_q + 24'h000001;
        if (!i_enable) begin
          state_d = ST_IDLE;
        end else if (ss_ok) begin
          state_d = ST_XFER;
        end else if (tmr_q == WIN_LAST) begin
          state_d = ST_OFF;
          tmr_d   = 24'h000000;
        end
      end
      ST_OFF: begin
        tmr_d = tmr_q + 24'h000001;
        if (!i_enable) begin
          state_d = ST_IDLE;
        end else if (tmr_q == OFF_LAST) begin
          tmr_d = 24'h000000;
          if (o_vin_half_mv > `PPC_PING_VIN_LAST - `PPC_PING_VIN_STEP) begin
            // ping supply exhausted; stay off until enable is cycled
            state_d = ST_IDLE;
            fail_d  = 1'b1;
          end else begin
            state_d = ST_PING;
            vin_d   = o_vin_half_mv + `PPC_PING_VIN_STEP;
          end
        end
      end
      ST_XFER: begin
        tmr_d = 24'h000000;
        if (!i_enable || is_end) begin
          state_d = ST_IDLE;
        end else if (is_ce) begin
          vin_d = vin_next;
          // voltage first, then frequency, then duty
          if (vin_sat) begin
            freq_d = freq_next;
            if (freq_sat) begin
              duty_d = duty_next;
            end
          end
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // held in idle after a failed sequence while enabled, so a stuck enable does not re-ping
  wire hold_fail = o_ping_fail && (state_q == ST_IDLE) && i_enable;

  // state and output registers
  always @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q       <= ST_IDLE;
      tmr_q         <= 24'h000000;
      o_power_en    <= 1'b0;
      o_vin_half_mv <= `PPC_PING_VIN_START;
      o_freq_hz     <= `PPC_FREQ_PING;
      o_duty_pmil   <= `PPC_DUTY_MAX;
      o_xfer_active <= 1'b0;
      o_ping_fail   <= 1'b0;
    end else begin
      // commands only ever take range-checked values
      if (!hold_fail) begin
        state_q       <= state_d;
        tmr_q         <= tmr_d;
        o_vin_half_mv <= vin_d;
        o_freq_hz     <= freq_d;
        o_duty_pmil   <= duty_d;
        o_power_en    <= (state_d == ST_PING) || (state_d == ST_XFER);
        o_xfer_active <= (state_d == ST_XFER);
      end
      if (!i_enable) begin
        o_ping_fail <= 1'b0;
      end else begin
        o_ping_fail <= fail_d;
      end
    end
  end

endmodule // ppc_ctrl

// >>> testbench/ppc_ctrl_monitor.sv
`timescale 1ns/1ns
`include "ppc_map.vh"
// ------------------------------
// port checker
// ------------------------------
module ppc_ctrl_monitor #(
  parameter PING_WIN_CYC = 20,
  parameter PING_OFF_CYC = 10
) (
  // clock, reset, control
  input wire        i_core_clk,
  input wire        i_rst_n,
  input wire        i_enable,
  // receiver side
  input wire        i_pkt_valid,
  input wire [7:0]  i_pkt_hdr,
  input wire [7:0]  i_pkt_data,
  input wire [15:0] i_coil_ma,
  // inverter side
  input wire        o_power_en,
  input wire [14:0] o_vin_half_mv,
  input wire [16:0] o_freq_hz,
  input wire [8:0]  o_duty_pmil,
  input wire        o_xfer_active,
  input wire        o_ping_fail
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  // control error taken in transfer
  wire       ce = i_pkt_valid && i_pkt_hdr == `PPC_HDR_CTRL_ERROR && o_xfer_active;
  reg [24:0] on_q;
  // ping burst length, cleared once transfer owns the power
  always @(posedge i_core_clk or negedge i_rst_n)
    if (!i_rst_n) on_q <= 25'h0;
    else on_q <= (o_power_en && !o_xfer_active) ? on_q + 25'h1 : 25'h0;

  a_vin_range: assert property (o_vin_half_mv >= `PPC_VIN_MIN
    && o_vin_half_mv <= `PPC_VIN_MAX) else $error("supply command out of range");
  a_freq_band: assert property (o_freq_hz >= `PPC_FREQ_MIN && o_freq_hz <= `PPC_FREQ_MAX)
    else $error("frequency out of band");
  a_duty_band: assert property (o_duty_pmil >= `PPC_DUTY_MIN
    && o_duty_pmil <= `PPC_DUTY_MAX) else $error("duty out of range");
  a_ping_start: assert property ($rose(o_power_en) |-> o_freq_hz == `PPC_FREQ_PING
    && o_vin_half_mv >= 15'h1B58 && o_vin_half_mv <= 15'h3A98) else $error("bad ping settings");
  a_ping_window: assert property (on_q <= PING_WIN_CYC)
    else $error("ping held too long");
  a_fail_off: assert property (o_ping_fail |-> !o_power_en)
    else $error("power on after ping failure");
  a_strength_ok: assert property (i_pkt_valid && i_pkt_hdr == `PPC_HDR_SIG_STRENGTH
    && i_pkt_data >= `PPC_SS_ACCEPT_MIN && o_power_en && !o_xfer_active && i_enable
    |=> o_xfer_active) else $error("strength not accepted");
  a_loop_cap: assert property (ce |=> o_vin_half_mv <= $past(o_vin_half_mv) + 1500
    && o_vin_half_mv + 1500 >= $past(o_vin_half_mv)) else $error("supply step over cap");
  a_volt_first: assert property (ce ##1 (o_vin_half_mv != `PPC_VIN_MIN
    && o_vin_half_mv != `PPC_VIN_MAX) |-> $stable(o_freq_hz) && $stable(o_duty_pmil))
    else $error("frequency moved before supply");
  a_end_power: assert property (o_xfer_active && i_pkt_valid
    && i_pkt_hdr == `PPC_HDR_END_POWER |=> !o_power_en && !o_xfer_active)
    else $error("end power ignored");
  c_xfer: cover property ($rose(o_xfer_active));
  c_fail: cover property ($rose(o_ping_fail));
  c_freq_top: cover property (o_freq_hz == `PPC_FREQ_MAX);
endmodule // ppc_ctrl_monitor

bind ppc_ctrl ppc_ctrl_monitor #(.PING_WIN_CYC(PING_WIN_CYC), .PING_OFF_CYC(PING_OFF_CYC))
  u_ppc_ctrl_monitor (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_enable(i_enable),
  .i_pkt_valid(i_pkt_valid), .i_pkt_hdr(i_pkt_hdr), .i_pkt_data(i_pkt_data),
  .i_coil_ma(i_coil_ma), .o_power_en(o_power_en), .o_vin_half_mv(o_vin_half_mv),
  .o_freq_hz(o_freq_hz), .o_duty_pmil(o_duty_pmil), .o_xfer_active(o_xfer_active),
  .o_ping_fail(o_ping_fail));

// >>> testbench/ppc_rx_model.sv
`timescale 1ns/1ns
`include "ppc_map.vh"
// ------------------------------
// receiver stand-in
// ------------------------------
module ppc_rx_model (
  // clock and reset
  input  wire       i_core_clk,
  input  wire       i_rst_n,
  // power signal and bench requests
  input  wire       i_power_en,
  input  wire [7:0] i_ss,
  input  wire       i_req,
  input  wire [7:0] i_hdr,
  input  wire [7:0] i_data,
  // decoded messages
  output reg        o_valid,
  output reg  [7:0] o_hdr,
  output reg  [7:0] o_data
);
  reg [1:0] age_q;
  // one strength answer per ping
  // zero strength means silence; idle payload toggles so stale data never looks valid
  always @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      age_q   <= 2'h0;
      o_valid <= 1'b0;
      o_hdr   <= 8'h00;
      o_data  <= 8'h00;
    end else begin
      age_q <= !i_power_en ? 2'h0 : (age_q == 2'h3) ? age_q : age_q + 2'h1;
      o_valid <= i_req || (age_q == 2'h2 && i_ss != 8'h00);
      o_hdr   <= i_req ? i_hdr : (age_q == 2'h2) ? `PPC_HDR_SIG_STRENGTH : ~o_hdr;
      o_data  <= i_req ? i_data : (age_q == 2'h2) ? i_ss : ~o_data;
    end
  end
endmodule // ppc_rx_model

// >>> testbench/ppc_ctrl_test.sv
`timescale 1ns/1ns
`include "ppc_map.vh"
// ------------------------------
// bench top
// ------------------------------
module ppc_ctrl_test;
  localparam WIN = 20;
  localparam OFF = 10;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        en = 1'b0;
  logic        req = 1'b0;
  logic [7:0]  hdr = 8'h00;
  logic [7:0]  dat = 8'h00;
  logic [7:0]  ss = 8'h00;
  logic [15:0] coil = 16'h0000;
  wire         pv, pe, xa, pf;
  wire  [7:0]  ph, pd;
  wire  [14:0] vin;
  wire  [16:0] frq;
  wire  [8:0]  duty;
  int          n_mismatch = 0;
  int          n_checks = 0;
  int          cyc = 0;

  ppc_rx_model u_ppc_rx_model (.i_core_clk(clk), .i_rst_n(rst_n), .i_power_en(pe),
    .i_ss(ss), .i_req(req), .i_hdr(hdr), .i_data(dat), .o_valid(pv), .o_hdr(ph), .o_data(pd));
  ppc_ctrl #(.PING_WIN_CYC(WIN), .PING_OFF_CYC(OFF)) u_ppc_ctrl (.i_core_clk(clk),
    .i_rst_n(rst_n), .i_enable(en), .i_pkt_valid(pv), .i_pkt_hdr(ph), .i_pkt_data(pd),
    .i_coil_ma(coil), .o_power_en(pe), .o_vin_half_mv(vin), .o_freq_hz(frq),
    .o_duty_pmil(duty), .o_xfer_active(xa), .o_ping_fail(pf));

  // 125 MHz core clock
  always #4 clk = ~clk;
  // hang guard, far above the few hundred cycles the run needs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      conclude();
    end
  end

  task automatic chk(input string nm, input logic [16:0] e, input logic [16:0] g);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %0d seen %0d", nm, e, g);
    end
  endtask
  // bounded wait on the power enable level
  task automatic wt(input logic v);
    int k;
    k = 0;
    while (pe !== v && k < 200) begin
      @(negedge clk);
      k++;
    end
    chk("power_en", v, pe);
  endtask
  // one receiver message through the model, judged after the answer edge
  task automatic send(input logic [7:0] h, input logic [7:0] d, input logic [15:0] c);
    @(posedge clk);
    req  <= 1'b1;
    hdr  <= h;
    dat  <= d;
    coil <= c;
    @(posedge clk);
    req <= 1'b0;
    @(posedge clk);
    @(negedge clk);
  endtask

  task automatic t_reset();
    @(negedge clk);
    chk("reset power", 1'b0, pe);
    chk("reset freq", `PPC_FREQ_PING, frq);
    chk("reset duty", `PPC_DUTY_MAX, duty);
  endtask
  // silent receiver: every retry steps the supply, then gives up
  task automatic t_ping_fail();
    int n;
    @(posedge clk);
    en <= 1'b1;
    for (int i = 0; i < 9; i++) begin
      wt(1'b1);
      chk("ping vin", 17'h1B58 + 17'h03E8 * i, vin);
      chk("ping freq", 17'h1A5E0, frq);
      n = 0;
      while (pe === 1'b1 && n < 100) begin
        @(negedge clk);
        n++;
      end
      chk("ping length", WIN, n);
    end
    repeat (OFF + 5) @(negedge clk);
    chk("ping fail", 1'b1, pf);
    chk("fail power", 1'b0, pe);
  endtask
  // strength just below, then at the accept level
  task automatic t_accept();
    @(posedge clk);
    en <= 1'b0;
    repeat (2) @(negedge clk);
    chk("fail cleared", 1'b0, pf);
    @(posedge clk);
    ss <= 8'h1F;
    en <= 1'b1;
    wt(1'b1);
    repeat (5) @(negedge clk);
    chk("low strength", 1'b0, xa);
    wt(1'b0);
    @(posedge clk);
    ss <= 8'h20;
    wt(1'b1);
    repeat (4) @(negedge clk);
    chk("accepted", 1'b1, xa);
    chk("second vin", 17'h1F40, vin);
  endtask
  // supply first, then frequency once the supply saturates, and duty once frequency saturates too
  task automatic t_loop();
    send(8'h03, 8'h80, 16'h03E8);
    chk("vin step", 17'h2328, vin);
    chk("freq held", 17'h1A5E0, frq);
    for (int k = 0; k < 3; k++) send(8'h03, 8'h7F, 16'hFFFF);
    chk("vin capped", 17'h1194, vin);
    send(8'h03, 8'h7F, 16'hFFFF);
    chk("vin floor", 17'h0FA0, vin);
    chk("freq top", 17'h1C138, frq);
    chk("duty floor", 17'h0014, duty);
    send(8'h03, 8'h80, 16'hFFFF);
    chk("vin raise", 17'h157C, vin);
    chk("freq kept", 17'h1C138, frq);
    send(8'h03, 8'h80, 16'h0005);
    chk("fine current", 17'h1581, vin);
    send(8'h02, 8'h00, 16'h0000);
    chk("end power", 1'b0, pe);
    chk("end xfer", 1'b0, xa);
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_ping_fail();
    t_accept();
    t_loop();
    conclude();
  end
endmodule // ppc_ctrl_test
